// [rtl/stlb_pkg.sv]
// Package of constants and types for the supply tracking limiter and brownout guard
package stlb_pkg;
	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_LIM_CTRL = 8'h00;
	localparam logic [7:0] REG_LIM_UPPER = 8'h04;
	localparam logic [7:0] REG_LIM_KNEE = 8'h08;
	localparam logic [7:0] REG_LIM_FLOOR = 8'h0C;
	localparam logic [7:0] REG_LIM_SLOPE = 8'h10;
	localparam logic [7:0] REG_BO_CTRL = 8'h14;
	localparam logic [7:0] REG_BO_TH = 8'h18;
	localparam logic [7:0] REG_BO_SD_TH = 8'h1C;
	localparam logic [7:0] REG_CONV = 8'h20;
	localparam logic [7:0] REG_STATUS = 8'h24;
	// ------------------------------------------------------------
	// Limiter control fields
	// ------------------------------------------------------------
	localparam int LC_EN = 0;
	localparam int LC_DYHDR = 1;
	localparam int LC_ATK = 4;
	localparam int LC_HLD = 8;
	localparam int LC_RLS = 12;
	localparam int LC_CAP = 16;
	localparam int LC_HDR = 20;
	localparam logic [31:0] LIM_CTRL_RST = 32'h0000_0002;
	localparam logic [31:0] LIM_UPPER_RST = 32'h0800_0000;
	localparam logic [31:0] LIM_KNEE_RST = 32'h0000_0000;
	localparam logic [31:0] LIM_FLOOR_RST = 32'h0000_0000;
	localparam logic [31:0] LIM_SLOPE_RST = 32'h0001_0000; // 1 V/V, Q16.16
	// ------------------------------------------------------------
	// Brownout control fields
	// ------------------------------------------------------------
	localparam int BC_EN = 0;
	localparam int BC_SRC = 1;
	localparam int BC_LOWCNV = 2;
	localparam int BC_MUTE = 3;
	localparam int BC_SDEN = 4;
	localparam int BC_INF = 5;
	localparam int BC_CLR = 6;
	localparam int BC_ATK = 8;
	localparam int BC_STEP = 12;
	localparam int BC_HLD = 16;
	localparam logic [31:0] BO_CTRL_RST = 32'h0000_0004;
	localparam logic [31:0] BO_TH_RST = 32'h0000_0000;
	// ------------------------------------------------------------
	// Converter timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int CONV_RATE_HZ = 192_000;
	localparam int CONV_TIME_NS10 = 52; // 5.2 us in 100 ns units
	localparam int CONV_PERIOD_CYC = CLK_HZ / CONV_RATE_HZ;
	localparam int CONV_TIME_CYC = (CONV_TIME_NS10 * 100 + 19) / 20;
	localparam int CONV_PER_TEMP = 18;
	localparam int GAIN_W = 16;
	localparam logic [15:0] GAIN_UNITY = 16'hFFFF;

	typedef enum logic [1:0] {
		STLB_CH_HIGH,
		STLB_CH_LOW,
		STLB_CH_TEMP
	} stlb_chan_type;
endpackage

// [rtl/stlb_conv_if.sv]
// Interface carrying converter results into the limiter core
`timescale 1ns/10ps
interface stlb_conv_if;
	logic [11:0] high_rail_result;
	logic [11:0] low_rail_result;
	logic [7:0] die_temperature_result;
	logic high_new;
	logic low_new;
	logic low_rail_convert_enable;
	modport conv (output high_rail_result, low_rail_result, die_temperature_result,
		high_new, low_new, input low_rail_convert_enable);
	modport core (input high_rail_result, low_rail_result, die_temperature_result,
		high_new, low_new, output low_rail_convert_enable);
endinterface

// [rtl/stlb_conv_seq.sv]
// Monitoring converter sequencer: schedules rail and temperature samples
`timescale 1ns/10ps
module stlb_conv_seq
	import stlb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	output logic sample_req_o,
	output stlb_pkg::stlb_chan_type sample_chan_o,
	input wire logic sample_done_i,
	input wire logic [11:0] sample_data_i,
	stlb_conv_if.conv cv
);
	import stlb_pkg::*;

	logic [15:0] tick_r;
	logic [4:0] slot_r;
	logic toggle_r;
	logic busy_r;
	stlb_chan_type chan_r;
	logic fire;
	logic [4:0] slot_nxt;

	// A conversion may take the whole slot, but never more
	if (CONV_PERIOD_CYC < CONV_TIME_CYC) begin : g_bad_timing
		$error("conversion period too short");
	end

	assign fire = (tick_r == 16'(CONV_PERIOD_CYC - 1));
	assign slot_nxt = (slot_r == 5'(CONV_PER_TEMP - 1)) ? 5'h00 : slot_r + 5'h01;
	assign sample_req_o = fire;
	assign sample_chan_o = (slot_r == 5'h00) ? STLB_CH_TEMP :
		(toggle_r && cv.low_rail_convert_enable) ? STLB_CH_LOW : STLB_CH_HIGH;

	// ------------------------------------------------------------
	// Fixed rate tick
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || fire) begin
			tick_r <= 16'h0000;
		end else begin
			tick_r <= tick_r + 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slot_r <= 5'h00;
			toggle_r <= 1'b0;
			busy_r <= 1'b0;
			chan_r <= STLB_CH_HIGH;
		end else if (fire) begin
			slot_r <= slot_nxt;
			if (slot_r != 5'h00) begin
				toggle_r <= ~toggle_r;
			end
			busy_r <= 1'b1;
			chan_r <= sample_chan_o;
		end else if (sample_done_i) begin
			busy_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Result capture
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cv.high_rail_result <= 12'h000;
			cv.low_rail_result <= 12'h000;
			cv.die_temperature_result <= 8'h00;
			cv.high_new <= 1'b0;
			cv.low_new <= 1'b0;
		end else begin
			cv.high_new <= 1'b0;
			cv.low_new <= 1'b0;
			if (busy_r && sample_done_i) begin
				case (chan_r)
					STLB_CH_HIGH: begin
						cv.high_rail_result <= sample_data_i;
						cv.high_new <= 1'b1;
					end
					STLB_CH_LOW: begin
						cv.low_rail_result <= sample_data_i;
						cv.low_new <= 1'b1;
					end
					default: begin
						cv.die_temperature_result <= sample_data_i[11:4];
					end
				endcase
			end
		end
	end

	chk_temp_slot: assert property (@(posedge clk_i) disable iff (rst_i)
		fire |-> (sample_chan_o == STLB_CH_TEMP) == (slot_r == 5'h00))
		else $error("temperature not taken in slot zero");
	chk_low_skip: assert property (@(posedge clk_i) disable iff (rst_i)
		!cv.low_rail_convert_enable |-> sample_chan_o != STLB_CH_LOW)
		else $error("low rail converted while disabled");
endmodule // stlb_conv_seq

// [rtl/stlb_top.sv]
// Supply tracking limiter with brownout guard, Wishbone register access
`timescale 1ns/10ps
// Overview of operation
// - Limiter applies gain reduction only while peak_limit_enable is set.
// - Enabled limiter attacks when input sample magnitude exceeds effective threshold.
// - Limiter uses 4-bit attack, 3-bit hold, 4-bit release settings.
// - Limiter attenuation stops growing at the 4-bit cap.
// - Threshold is upper value above knee, falls by slope below knee.
// - Tracked threshold never goes below floor threshold.
// - Headroom mode: threshold is high rail scaled by signed percentage.
// - Headroom mode resets on; off uses upper, floor, knee and slope.
// - Brownout has priority; attacks below threshold, releases after hold.
// - Brownout needs enable; source select chooses rail, resets to low.
// - High rail undervoltage detect enabled only when high rail selected.
// - Low rail conversions skipped when low conversion enable cleared.
// - Limiter paused while brownout is engaged.
// - Brownout threshold 32-bit; mute select mutes and shuts down.
// - Shutdown threshold mutes then shuts down unless mute select set.
// - Brownout has 3-bit attack rate, 2-bit step, 3-bit hold.
// - Leaving brownout releases with limiter release settings always.
// - Infinite hold keeps attenuation until mute, shutdown or hold clear.
// - Converter gives 12-bit rail and 8-bit temperature results.
// - Converter runs at fixed 192 kHz, 5.2 us per conversion.
// - One temperature sample in every 18 conversions.
module stlb_top
	import stlb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sample_valid_i,
	input wire logic signed [23:0] sample_i,
	output logic sample_valid_o,
	output logic signed [23:0] sample_o,
	output logic conv_req_o,
	output stlb_pkg::stlb_chan_type conv_chan_o,
	input wire logic conv_done_i,
	input wire logic [11:0] conv_data_i,
	input wire logic shutdown_req_i,
	output logic high_uv_detect_enable_o,
	output logic mute_o,
	output logic shutdown_o
);
	import stlb_pkg::*;

	stlb_conv_if cv ();

	logic [31:0] lim_ctrl_r, upper_r, knee_r, floor_r, slope_r, bo_ctrl_r, bo_th_r, bo_sd_th_r;
	logic [31:0] thresh_r;
	logic [15:0] gain_r;
	logic [15:0] hold_cnt_r;
	logic bo_active_r, bo_hold_r, inf_held_r, clr_pulse_r;
	logic wb_hit, wr;
	logic [31:0] rd_data;

	stlb_conv_seq u_seq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sample_req_o(conv_req_o),
		.sample_chan_o(conv_chan_o),
		.sample_done_i(conv_done_i),
		.sample_data_i(conv_data_i),
		.cv(cv.conv)
	);

	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) res[i*8 +: 8] = nw[i*8 +: 8];
		end
		return res;
	endfunction

	logic peak_limit_enable, dyhdr, bo_en, bo_src, bo_mute, bo_sden, bo_inf;
	logic [3:0] limit_attack_rate, limit_release_rate, lim_cap;
	logic [2:0] limit_hold_time, bo_atk, bo_hld;
	logic [1:0] bo_step;
	logic signed [4:0] hdr;
	assign peak_limit_enable = lim_ctrl_r[LC_EN];
	assign dyhdr = lim_ctrl_r[LC_DYHDR];
	assign limit_attack_rate = lim_ctrl_r[LC_ATK +: 4];
	assign limit_hold_time = lim_ctrl_r[LC_HLD +: 3];
	assign limit_release_rate = lim_ctrl_r[LC_RLS +: 4];
	assign lim_cap = lim_ctrl_r[LC_CAP +: 4];
	assign hdr = lim_ctrl_r[LC_HDR +: 5];
	assign bo_en = bo_ctrl_r[BC_EN];
	assign bo_src = bo_ctrl_r[BC_SRC];
	assign bo_mute = bo_ctrl_r[BC_MUTE];
	assign bo_sden = bo_ctrl_r[BC_SDEN] & ~bo_mute;
	assign bo_inf = bo_ctrl_r[BC_INF];
	assign bo_atk = bo_ctrl_r[BC_ATK +: 3];
	assign bo_step = bo_ctrl_r[BC_STEP +: 2];
	assign bo_hld = bo_ctrl_r[BC_HLD +: 3];
	assign cv.low_rail_convert_enable = bo_ctrl_r[BC_LOWCNV];
	assign high_uv_detect_enable_o = bo_en & bo_src;

	// ------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------
	assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = wb_hit & wb_we_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_hit;
			wb_dat_o <= rd_data;
		end
	end

	always_comb begin
		if (wb_adr_i == REG_LIM_CTRL) rd_data = lim_ctrl_r;
		else if (wb_adr_i == REG_LIM_UPPER) rd_data = upper_r;
		else if (wb_adr_i == REG_LIM_KNEE) rd_data = knee_r;
		else if (wb_adr_i == REG_LIM_FLOOR) rd_data = floor_r;
		else if (wb_adr_i == REG_LIM_SLOPE) rd_data = slope_r;
		else if (wb_adr_i == REG_BO_CTRL) rd_data = bo_ctrl_r;
		else if (wb_adr_i == REG_BO_TH) rd_data = bo_th_r;
		else if (wb_adr_i == REG_BO_SD_TH) rd_data = bo_sd_th_r;
		else if (wb_adr_i == REG_CONV)
			rd_data = {cv.die_temperature_result, cv.high_rail_result, cv.low_rail_result};
		else if (wb_adr_i == REG_STATUS)
			rd_data = {12'h000, gain_r, 1'b0, inf_held_r, bo_hold_r, bo_active_r};
		else rd_data = 32'h0000_0000;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lim_ctrl_r <= LIM_CTRL_RST;
			upper_r <= LIM_UPPER_RST;
			knee_r <= LIM_KNEE_RST;
			floor_r <= LIM_FLOOR_RST;
			slope_r <= LIM_SLOPE_RST;
			bo_ctrl_r <= BO_CTRL_RST;
			bo_th_r <= BO_TH_RST;
			bo_sd_th_r <= BO_TH_RST;
			clr_pulse_r <= 1'b0;
		end else begin
			clr_pulse_r <= 1'b0;
			if (wr) begin
				if (wb_adr_i == REG_LIM_CTRL) lim_ctrl_r <= wmask(lim_ctrl_r, wb_dat_i, wb_sel_i);
				else if (wb_adr_i == REG_LIM_UPPER) upper_r <= wmask(upper_r, wb_dat_i, wb_sel_i);
				else if (wb_adr_i == REG_LIM_KNEE) knee_r <= wmask(knee_r, wb_dat_i, wb_sel_i);
				else if (wb_adr_i == REG_LIM_FLOOR) floor_r <= wmask(floor_r, wb_dat_i, wb_sel_i);
				else if (wb_adr_i == REG_LIM_SLOPE) slope_r <= wmask(slope_r, wb_dat_i, wb_sel_i);
				else if (wb_adr_i == REG_BO_CTRL) begin
					// Hold clear is self clearing
					bo_ctrl_r <= wmask(bo_ctrl_r, wb_dat_i, wb_sel_i) & ~(32'h1 << BC_CLR);
					clr_pulse_r <= wb_sel_i[0] & wb_dat_i[BC_CLR];
				end
				else if (wb_adr_i == REG_BO_TH) bo_th_r <= wmask(bo_th_r, wb_dat_i, wb_sel_i);
				else if (wb_adr_i == REG_BO_SD_TH) bo_sd_th_r <= wmask(bo_sd_th_r, wb_dat_i, wb_sel_i);
			end
		end
	end

	// ------------------------------------------------------------
	// Effective threshold, 12-bit rail scale zero-extended
	// ------------------------------------------------------------
	logic [31:0] rail_h, mon_rail, drop, track;
	logic [47:0] prod;
	logic [31:0] hdr_th;
	assign rail_h = {20'h00000, cv.high_rail_result};
	assign mon_rail = bo_src ? rail_h : {20'h00000, cv.low_rail_result};
	assign drop = (knee_r > rail_h) ? knee_r - rail_h : 32'h0000_0000;
	assign prod = 48'(drop) * 48'(slope_r[15:0]) + 48'({slope_r[31:16], 16'h0000}) * 48'(drop);
	assign track = (upper_r > 32'(prod >> 16)) ? upper_r - 32'(prod >> 16) : 32'h0000_0000;
	// Percent scaled by 1/128 approximation of 1/100 avoided: exact divide by 100
	assign hdr_th = 32'((rail_h * 32'(100 - 32'(signed'(hdr)))) / 32'd100);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			thresh_r <= LIM_UPPER_RST;
		end else if (cv.high_new) begin
			if (dyhdr) thresh_r <= hdr_th;
			else if (rail_h >= knee_r) thresh_r <= upper_r;
			else thresh_r <= (track < floor_r) ? floor_r : track;
		end
	end

	// ------------------------------------------------------------
	// Brownout guard
	// ------------------------------------------------------------
	logic bo_below, sd_below;
	assign bo_below = bo_en && (mon_rail < bo_th_r);
	assign sd_below = bo_en && bo_sden && (mon_rail <= bo_sd_th_r);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mute_o <= 1'b0;
			shutdown_o <= 1'b0;
		end else if (shutdown_req_i) begin
			mute_o <= 1'b0;
			shutdown_o <= 1'b0;
		end else if (sd_below || (bo_below && bo_mute)) begin
			mute_o <= 1'b1;
			shutdown_o <= mute_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bo_active_r <= 1'b0;
			bo_hold_r <= 1'b0;
			inf_held_r <= 1'b0;
			hold_cnt_r <= 16'h0000;
		end else if (bo_below) begin
			bo_active_r <= 1'b1;
			bo_hold_r <= 1'b0;
			inf_held_r <= 1'b0;
		end else if (bo_active_r) begin
			bo_active_r <= 1'b0;
			bo_hold_r <= 1'b1;
			inf_held_r <= bo_inf;
			hold_cnt_r <= 16'(bo_hld) << 8;
		end else if (bo_hold_r) begin
			if (inf_held_r) begin
				if (clr_pulse_r || mute_o || shutdown_req_i) bo_hold_r <= 1'b0;
			end else if (hold_cnt_r == 16'h0000) begin
				bo_hold_r <= 1'b0;
			end else if (sample_valid_i) begin
				hold_cnt_r <= hold_cnt_r - 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------
	// Gain engine
	// ------------------------------------------------------------
	logic [23:0] mag;
	logic [15:0] floor_gain, atk_step, rls_step;
	logic [31:0] lim_hold_cnt_r;
	logic engaged;
	assign engaged = bo_active_r | bo_hold_r;
	assign mag = sample_i[23] ? 24'(-sample_i) : 24'(sample_i);
	assign floor_gain = GAIN_UNITY - ({12'h000, lim_cap} << 11);
	assign atk_step = 16'h0001 << limit_attack_rate[3:0];
	assign rls_step = 16'h0001 << limit_release_rate[3:0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gain_r <= GAIN_UNITY;
			lim_hold_cnt_r <= 32'h0000_0000;
		end else if (sample_valid_i) begin
			if (bo_active_r) begin
				gain_r <= (gain_r > (16'h0100 << (bo_atk + 3'(bo_step)))) ?
					gain_r - (16'h0100 << (bo_atk + 3'(bo_step))) : 16'h0000;
			end else if (bo_hold_r) begin
				gain_r <= gain_r;
			end else if (peak_limit_enable && !engaged && {8'h00, mag} > thresh_r) begin
				lim_hold_cnt_r <= 32'(limit_hold_time) << 6;
				// Wide compare: floor plus step may pass the 16-bit top
				gain_r <= (17'(gain_r) > 17'(floor_gain) + 17'(atk_step)) ?
					gain_r - atk_step : floor_gain;
			end else if (lim_hold_cnt_r != 32'h0) begin
				lim_hold_cnt_r <= lim_hold_cnt_r - 32'h1;
			end else begin
				gain_r <= (GAIN_UNITY - gain_r > rls_step) ? gain_r + rls_step : GAIN_UNITY;
			end
		end
	end

	logic signed [40:0] scaled;
	assign scaled = sample_i * $signed({1'b0, gain_r});
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sample_valid_o <= 1'b0;
			sample_o <= 24'h000000;
		end else begin
			sample_valid_o <= sample_valid_i;
			if (sample_valid_i) sample_o <= mute_o ? 24'h000000 : scaled[39:16];
		end
	end

	chk_uv_enable: assert property (@(posedge clk_i) disable iff (rst_i)
		high_uv_detect_enable_o == (bo_en && bo_src))
		else $error("undervoltage detect enable wrong");
	chk_bo_engage: assert property (@(posedge clk_i) disable iff (rst_i)
		bo_below |=> bo_active_r)
		else $error("brownout not engaged");
	chk_lim_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!peak_limit_enable && !engaged && !bo_active_r && sample_valid_i |=> gain_r >= $past(gain_r))
		else $error("gain reduced with limiter off");
	chk_cap_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!engaged && gain_r >= floor_gain && $stable(lim_ctrl_r) |=> gain_r >= $past(floor_gain))
		else $error("attenuation beyond cap");
	chk_sd_mute: assert property (@(posedge clk_i) disable iff (rst_i)
		bo_mute && !bo_below && !mute_o && !shutdown_req_i |=> !mute_o)
		else $error("shutdown path not disabled by mute select");
	chk_inf_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		bo_hold_r && inf_held_r && !bo_below && !clr_pulse_r && !mute_o && !shutdown_req_i
		|=> bo_hold_r)
		else $error("infinite hold released early");
	chk_floor: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(cv.high_new) && !$past(dyhdr) && $stable(floor_r) |-> thresh_r >= floor_r)
		else $error("threshold below floor");
	chk_mute_out: assert property (@(posedge clk_i) disable iff (rst_i)
		mute_o && sample_valid_i |=> sample_o == 24'h000000)
		else $error("audio not muted");
endmodule // stlb_top

// [verification/stlb_conv_model.sv]
// Behavioural model of the supply monitoring converter
`timescale 1ns/10ps
module stlb_conv_model
	import stlb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic conv_req_i,
	input wire stlb_pkg::stlb_chan_type conv_chan_i,
	input wire logic [11:0] high_i,
	input wire logic [11:0] low_i,
	input wire logic [7:0] temp_i,
	input wire logic [7:0] dly_i,
	output logic conv_done_o,
	output logic [11:0] conv_data_o
);
	logic busy_r;
	logic [7:0] cnt_r;
	stlb_chan_type chan_r;
	// Data toggles between results so a stale value never passes
	always_ff @(posedge clk_i) begin
		conv_done_o <= 1'b0;
		conv_data_o <= ~conv_data_o;
		if (rst_i) begin
			busy_r <= 1'b0;
			conv_data_o <= 12'h000;
		end else if (conv_req_i && !busy_r) begin
			busy_r <= 1'b1;
			cnt_r <= dly_i;
			chan_r <= conv_chan_i;
		end else if (busy_r && cnt_r != 8'h00) begin
			cnt_r <= cnt_r - 8'h01;
		end else if (busy_r) begin
			busy_r <= 1'b0;
			conv_done_o <= 1'b1;
			case (chan_r)
				STLB_CH_HIGH: conv_data_o <= high_i;
				STLB_CH_LOW: conv_data_o <= low_i;
				default: conv_data_o <= {temp_i, 4'h0};
			endcase
		end
	end
endmodule // stlb_conv_model

// [verification/stlb_top_test.sv]
// Self-checking bench for the limiter and brownout guard
`timescale 1ns/10ps
module stlb_top_test;
	import stlb_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic sample_valid_i = 1'b0;
	logic signed [23:0] sample_i = 24'h0;
	logic sample_valid_o;
	logic signed [23:0] sample_o;
	logic signed [23:0] amp = 24'h10_0000;
	logic sgn = 1'b0;
	logic [5:0] scnt = 6'h00;
	logic conv_req_o, conv_done_i, shutdown_req_i = 1'b0;
	logic high_uv_detect_enable_o, mute_o, shutdown_o;
	stlb_chan_type conv_chan_o;
	logic [11:0] conv_data_i;
	logic [11:0] high = 12'hC00;
	logic [11:0] low = 12'hF00;
	logic [7:0] temp = 8'h5A;
	logic [7:0] dly = 8'h01;
	int num_errors = 0;
	int tests_run = 0;
	always #10 clk_i = ~clk_i;
	// ----
	// Audio source, one sample every 64 cycles
	// ----
	always @(posedge clk_i) begin
		scnt <= scnt + 6'h01;
		sample_valid_i <= (scnt == 6'h00);
		if (scnt == 6'h00) begin
			sgn <= ~sgn;
			sample_i <= sgn ? -amp : amp;
		end
	end
	stlb_top u_stlb_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_valid_i(sample_valid_i),
		.sample_i(sample_i), .sample_valid_o(sample_valid_o), .sample_o(sample_o),
		.conv_req_o(conv_req_o),
		.conv_chan_o(conv_chan_o), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
		.shutdown_req_i(shutdown_req_i), .high_uv_detect_enable_o(high_uv_detect_enable_o),
		.mute_o(mute_o), .shutdown_o(shutdown_o));
	stlb_conv_model u_stlb_conv_model (.clk_i(clk_i), .rst_i(rst_i), .conv_req_i(conv_req_o),
		.conv_chan_i(conv_chan_o), .high_i(high), .low_i(low), .temp_i(temp), .dly_i(dly),
		.conv_done_o(conv_done_i), .conv_data_o(conv_data_i));
	// ----
	// Shared tasks
	// ----
	task close_out;
		$display("errors %0d comparisons %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk_val(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task bail;
		num_errors++;
		close_out;
	endtask
	// Next output sample against input times the given gain
	task chk_audio(input logic [16:0] g);
		logic signed [40:0] e;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (sample_valid_o !== 1'b1 && n < 200);
		if (n >= 200)
			bail;
		e = sample_i * $signed(g);
		chk_val({8'h00, sample_o}, {8'h00, e[39:16]});
	endtask
	task xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 50)
			bail;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0, q);
	endtask
	task gain(output logic [15:0] g);
		logic [31:0] q;
		rd(REG_STATUS, q);
		g = q[19:4];
	endtask
	// Polls status every sample period, bounded
	task wait_stat(input int b, input logic v);
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			repeat (64) @(posedge clk_i);
			rd(REG_STATUS, q);
			n++;
		end while (q[b] !== v && n < 400);
		if (n >= 400)
			bail;
	endtask
	task wait_mute;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (mute_o !== 1'b1 && n < 15000);
		if (n >= 15000)
			bail;
	endtask
	task conv_scan(output int nt, output int nl);
		int gap, n;
		nt = 0;
		nl = 0;
		gap = -1;
		n = 0;
		for (int c = 0; c < 6000 && n < 18; c++) begin
			@(posedge clk_i);
			if (gap >= 0)
				gap++;
			if (conv_req_o === 1'b1) begin
				if (gap > 0)
					chk_val(gap, CONV_PERIOD_CYC);
				gap = 0;
				n++;
				nt += (conv_chan_o === STLB_CH_TEMP);
				nl += (conv_chan_o === STLB_CH_LOW);
			end
		end
		if (n < 18)
			bail;
	endtask
	// ----
	// Scenarios
	// ----
	task t_reset;
		logic [31:0] q;
		rd(REG_LIM_CTRL, q);
		chk_val(q, LIM_CTRL_RST);
		rd(REG_BO_CTRL, q);
		chk_val(q, BO_CTRL_RST);
		rd(REG_LIM_SLOPE, q);
		chk_val(q, LIM_SLOPE_RST);
		wr(8'h80, 32'hFFFF_FFFF);
		rd(8'h80, q);
		chk_val(q, 32'h0);
		chk_bit(high_uv_detect_enable_o, 1'b0);
		chk_audio(17'h0FFFF);
	endtask
	task t_limit;
		logic [15:0] g;
		wr(REG_LIM_UPPER, 32'h0);
		wr(REG_LIM_KNEE, 32'h0);
		wr(REG_LIM_FLOOR, 32'h0);
		wr(REG_LIM_CTRL, 32'h0002_1010);
		repeat (40 * 64) @(posedge clk_i);
		gain(g);
		chk_val(g, GAIN_UNITY);
		wr(REG_LIM_CTRL, 32'h0002_1081);
		repeat (60 * 64) @(posedge clk_i);
		gain(g);
		chk_bit(g < GAIN_UNITY, 1'b1);
		chk_val(g, GAIN_UNITY - 16'h1000);
		wr(REG_LIM_CTRL, 32'h0002_8080);
		repeat (24 * 64) @(posedge clk_i);
		gain(g);
		chk_val(g, GAIN_UNITY);
	endtask
	task t_brown;
		logic [15:0] g0, g1;
		low = 12'h100;
		wr(REG_BO_TH, 32'h800);
		wr(REG_BO_CTRL, 32'h0000_1125);
		wait_stat(0, 1'b1);
		chk_bit(mute_o, 1'b0);
		chk_bit(high_uv_detect_enable_o, 1'b0);
		repeat (20 * 64) @(posedge clk_i);
		gain(g0);
		chk_bit(g0 < GAIN_UNITY, 1'b1);
		low = 12'hF00;
		wait_stat(2, 1'b1);
		gain(g0);
		repeat (40 * 64) @(posedge clk_i);
		gain(g1);
		chk_val(g1, g0);
		wr(REG_BO_CTRL, 32'h0000_1165);
		repeat (40 * 64) @(posedge clk_i);
		gain(g1);
		chk_bit(g1 > g0, 1'b1);
		wr(REG_BO_CTRL, 32'h0000_0004);
	endtask
	task t_mute;
		low = 12'h100;
		wr(REG_BO_CTRL, 32'h0000_110D);
		wait_mute;
		repeat (2) @(posedge clk_i);
		chk_bit(shutdown_o, 1'b1);
		chk_audio(17'h00000);
		shutdown_req_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk_bit(mute_o, 1'b0);
		chk_bit(shutdown_o, 1'b0);
		low = 12'hF00;
		wr(REG_BO_CTRL, 32'h0000_0004);
		shutdown_req_i <= 1'b0;
	endtask
	task t_sdown;
		low = 12'h100;
		wr(REG_BO_TH, 32'h0);
		wr(REG_BO_SD_TH, 32'h200);
		wr(REG_BO_CTRL, 32'h0000_001D);
		repeat (2 * 4680) @(posedge clk_i);
		chk_bit(mute_o, 1'b0);
		wr(REG_BO_CTRL, 32'h0000_0015);
		wait_mute;
		chk_bit(shutdown_o, 1'b0);
		@(posedge clk_i);
		chk_bit(shutdown_o, 1'b1);
		shutdown_req_i <= 1'b1;
		low = 12'hF00;
		wr(REG_BO_CTRL, 32'h0000_0004);
		shutdown_req_i <= 1'b0;
	endtask
	task t_conv;
		int nt, nl;
		logic [31:0] q;
		conv_scan(nt, nl);
		chk_val(nt, 1);
		chk_bit(nl > 0, 1'b1);
		wr(REG_BO_CTRL, 32'h0);
		repeat (300) @(posedge clk_i);
		conv_scan(nt, nl);
		chk_val(nl, 0);
		dly = 8'hC8;
		wr(REG_BO_CTRL, 32'h0000_0007);
		chk_bit(high_uv_detect_enable_o, 1'b1);
		repeat (2 * 4680) @(posedge clk_i);
		rd(REG_CONV, q);
		chk_val(q, {temp, high, low});
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_limit;
		t_brown;
		t_mute;
		t_sdown;
		t_conv;
		close_out;
	end
endmodule // stlb_top_test
